// ---- verilog/pfc_fault_pkg.sv ----
// Purpose: Shared constants and types for the PFC fault supervisor
// Assumes: Sense codes are scaled so that one LSB equals one volt; 40 MHz clock
// Notes:   Default thresholds are plain starting values, overridable on the top module
package pfc_fault_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 25;
  localparam int NS_PER_MS         = 1000000;
  localparam int CYC_PER_MS        = NS_PER_MS / CLK_PERIOD_NS;
  localparam int TROUGH_MS         = 8;
  localparam int BROWNOUT_MS       = 56;
  localparam int RESTART_MS        = 3000;
  localparam int STARTUP_LIMIT_MS  = 500;
  localparam int OSC_SETTLE_MS     = 200;
  localparam int TROUGH_CYC        = TROUGH_MS * CYC_PER_MS;
  localparam int BROWNOUT_CYC      = BROWNOUT_MS * CYC_PER_MS;
  localparam int RESTART_CYC       = RESTART_MS * CYC_PER_MS;
  localparam int STARTUP_LIMIT_CYC = STARTUP_LIMIT_MS * CYC_PER_MS;
  localparam int OSC_SETTLE_CYC    = OSC_SETTLE_MS * CYC_PER_MS;
  localparam int CNT_W             = 27;

  // ---------------------------------------------------------------------------
  // Levels (codes in volts)
  // ---------------------------------------------------------------------------
  localparam int        CODE_W             = 12;
  localparam int        PCT_BASE           = 100;
  localparam int        STARTUP_ENTER_PCT  = 90;
  localparam int        OVP_PCT            = 105;
  localparam logic [11:0] NOMINAL_LINK_CODE = 12'h190;
  localparam logic [11:0] STARTUP_ENTER_CODE = 12'(int'(NOMINAL_LINK_CODE) * STARTUP_ENTER_PCT / PCT_BASE);
  localparam logic [11:0] OVP_CODE          = 12'(int'(NOMINAL_LINK_CODE) * OVP_PCT / PCT_BASE);
  localparam logic [11:0] LINE_CLAMP_CODE   = 12'h080;
  localparam logic [11:0] TROUGH_STEP_CODE  = 12'h005;
  localparam logic [11:0] BROWNOUT_LOWER_DEF = 12'h05F;
  localparam logic [11:0] BROWNOUT_UPPER_DEF = 12'h069;
  localparam logic [11:0] OVP_HYST_DEF      = 12'h00A;
  localparam logic [2:0]  OSC_ENTRY_LIMIT   = 3'h4;

  // On-time ceiling: 0.001126 V*s over line volts, in cycles
  localparam int          ON_TIME_VNS      = 1126000;
  localparam logic [15:0] ON_TIME_NUM      = 16'(ON_TIME_VNS / CLK_PERIOD_NS);

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_STARTUP   = 2'b00,
    MODE_NORMAL    = 2'b01,
    MODE_OVERPOWER = 2'b10,
    MODE_STANDBY   = 2'b11
  } op_mode_t;

  typedef struct packed {
    logic        valid;
    logic [11:0] link;
    logic [11:0] line;
  } sense_sample_t;

  typedef struct packed {
    logic startup;
    logic overvoltage;
    logic loop_fault;
    logic brownout;
    logic overpower;
    logic low_power;
  } supervisor_status_t;

  function automatic logic [11:0] min_code(input logic [11:0] a, input logic [11:0] b);
    min_code = (a < b) ? a : b;
  endfunction

endpackage

// ---- verilog/line_peak_estimator.sv ----
// Purpose: Filtered estimate of the line voltage peak, updated at each trough
// Assumes: Samples arrive on the same clock; one trough every TROUGH_CYC cycles
// Notes:   Estimate rises to the half-cycle maximum, capped at the clamp ceiling
`timescale 1ns/1ps
module line_peak_estimator #(
  parameter int TROUGH_CYC = pfc_fault_pkg::TROUGH_CYC
) (
  input  wire logic                         sys_clk,
  input  wire logic                         rst,
  input  wire pfc_fault_pkg::sense_sample_t sample,
  output logic [11:0]                       peak_r,
  output logic                              trough_r
);

  typedef struct packed {
    logic [pfc_fault_pkg::CNT_W-1:0] trough_cnt;
    logic [11:0]                     half_max;
    logic [11:0]                     peak;
    logic                            trough;
  } peak_state_t;

  peak_state_t st_r;
  peak_state_t st_nxt;

  // ---------------------------------------------------------------------------
  // Half-cycle maximum and trough update
  // ---------------------------------------------------------------------------
  always_comb begin
    st_nxt        = st_r;
    st_nxt.trough = 1'b0;
    if (sample.valid && sample.line > st_r.half_max) begin
      st_nxt.half_max = sample.line;
    end
    if (st_r.trough_cnt >= pfc_fault_pkg::CNT_W'(TROUGH_CYC - 1)) begin
      st_nxt.trough_cnt = '0;
      st_nxt.trough     = 1'b1;
      st_nxt.half_max   = '0;
      if (st_r.half_max >= st_r.peak) begin
        st_nxt.peak = pfc_fault_pkg::min_code(st_r.half_max, pfc_fault_pkg::LINE_CLAMP_CODE);
      end else if (st_r.peak - st_r.half_max > pfc_fault_pkg::TROUGH_STEP_CODE) begin
        st_nxt.peak = st_r.peak - pfc_fault_pkg::TROUGH_STEP_CODE;
      end else begin
        st_nxt.peak = st_r.half_max;
      end
    end else begin
      st_nxt.trough_cnt = st_r.trough_cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign peak_r   = st_r.peak;
  assign trough_r = st_r.trough;

endmodule

// ---- verilog/pfc_fault_supervisor.sv ----
// Purpose: Protection supervisor deciding when the PFC gate drive may switch
// Assumes: Digitised link and line sense codes on sys_clk; standby pin is asynchronous
// Notes:   Long counts are parameters so simulation can shorten them
`timescale 1ns/1ps
module pfc_fault_supervisor #(
  parameter int          TROUGH_CYC        = pfc_fault_pkg::TROUGH_CYC,
  parameter int          BROWNOUT_CYC      = pfc_fault_pkg::BROWNOUT_CYC,
  parameter int          RESTART_CYC       = pfc_fault_pkg::RESTART_CYC,
  parameter int          STARTUP_LIMIT_CYC = pfc_fault_pkg::STARTUP_LIMIT_CYC,
  parameter int          OSC_SETTLE_CYC    = pfc_fault_pkg::OSC_SETTLE_CYC,
  parameter logic [11:0] BROWNOUT_LOWER    = pfc_fault_pkg::BROWNOUT_LOWER_DEF,
  parameter logic [11:0] BROWNOUT_UPPER    = pfc_fault_pkg::BROWNOUT_UPPER_DEF,
  parameter logic [11:0] OVP_HYST          = pfc_fault_pkg::OVP_HYST_DEF
) (
  input  wire logic                              sys_clk,
  input  wire logic                              rst,
  input  wire pfc_fault_pkg::sense_sample_t      sample,
  input  wire logic                              low_power_request_n,
  output logic                                   gate_enable_r,
  output pfc_fault_pkg::supervisor_status_t      status_r,
  output logic signed [12:0]                     link_error_r,
  output logic [15:0]                            on_time_limit_r,
  output logic [11:0]                            line_peak_r
);

  // Width of every long counter
  localparam int CW = pfc_fault_pkg::CNT_W;

  typedef struct packed {
    logic                              lp_s1;
    logic                              lp_s2;
    pfc_fault_pkg::op_mode_t           mode;
    logic [11:0]                       link;
    logic [11:0]                       line;
    logic                              ovp;
    logic                              loop_fault;
    logic                              brownout;
    logic                              bo_retry;
    logic [CW-1:0]                     bo_cnt;
    logic [CW-1:0]                     retry_cnt;
    logic [CW-1:0]                     op_cnt;
    logic [CW-1:0]                     su_cnt;
    logic [CW-1:0]                     settle_cnt;
    logic [2:0]                        osc_cnt;
    logic                              gate;
    pfc_fault_pkg::supervisor_status_t status;
    logic signed [12:0]                err;
    logic [15:0]                       on_lim;
    logic [11:0]                       peak_out;
  } sup_state_t;

  // Registered state and its next value
  sup_state_t  st_r;
  sup_state_t  st_nxt;
  logic [11:0] peak;

  // ---------------------------------------------------------------------------
  // Line peak estimate
  // ---------------------------------------------------------------------------
  line_peak_estimator #(
    .TROUGH_CYC (TROUGH_CYC)
  ) u_peak (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .sample   (sample),
    .peak_r   (peak),
    .trough_r ()
  );

  // ---------------------------------------------------------------------------
  // On-time ceiling
  // ---------------------------------------------------------------------------
  function automatic logic [15:0] on_time_ceiling(input logic [11:0] line_code);
    logic [15:0] div;
    // Guard the divide against a zero line code
    div = (line_code == 12'h000) ? 16'h0001 : {4'h0, line_code};
    on_time_ceiling = pfc_fault_pkg::ON_TIME_NUM / div;
  endfunction

  // ---------------------------------------------------------------------------
  // Supervisor next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic standby;
    standby = 1'b0;
    st_nxt  = st_r;

    st_nxt.lp_s1 = low_power_request_n;
    st_nxt.lp_s2 = st_r.lp_s1;
    standby      = !st_r.lp_s2;

    // Hold the last valid conversion
    if (sample.valid) begin
      st_nxt.link = sample.link;
      st_nxt.line = sample.line;
    end

    st_nxt.err = 13'(signed'({1'b0, pfc_fault_pkg::NOMINAL_LINK_CODE})) - 13'(signed'({1'b0, st_r.link}));

    st_nxt.on_lim   = on_time_ceiling(st_r.line);
    st_nxt.peak_out = peak;

    // ---------------------------------------------------------------------------
    // Fault flags
    // ---------------------------------------------------------------------------
    // immediate overvoltage stop
    if (sample.valid && sample.link > pfc_fault_pkg::OVP_CODE) begin
      st_nxt.ovp = 1'b1;
    end else if (st_r.ovp && st_r.link < pfc_fault_pkg::OVP_CODE - OVP_HYST) begin
      st_nxt.ovp = 1'b0;
    end

    if (sample.valid && sample.link < sample.line) begin
      st_nxt.loop_fault = 1'b1;
    end else if (st_r.loop_fault && st_r.link >= st_r.line && st_r.link > peak) begin
      st_nxt.loop_fault = 1'b0;
    end

    // Brownout timer counts in both directions
    // zero line reads as low peak
    if (!st_r.brownout) begin
      if (peak < BROWNOUT_LOWER) begin
        st_nxt.bo_cnt = st_r.bo_cnt + 1'b1;
        if (st_r.bo_cnt > CW'(BROWNOUT_CYC)) begin
          st_nxt.brownout  = 1'b1;
          st_nxt.bo_cnt    = '0;
          st_nxt.retry_cnt = '0;
        end
      end else begin
        st_nxt.bo_cnt = '0;
      end
    end else begin
      // exit after 56 ms above upper
      if (peak > BROWNOUT_UPPER) begin
        st_nxt.bo_cnt = st_r.bo_cnt + 1'b1;
        if (st_r.bo_cnt >= CW'(BROWNOUT_CYC - 1)) begin
          st_nxt.brownout = 1'b0;
          st_nxt.bo_cnt   = '0;
          st_nxt.bo_retry = 1'b0;
        end
      end else begin
        st_nxt.bo_cnt = '0;
      end

      if (st_r.retry_cnt >= CW'(RESTART_CYC + TROUGH_CYC - 1)) begin
        st_nxt.retry_cnt = '0;
        st_nxt.bo_retry  = 1'b0;
      end else begin
        st_nxt.retry_cnt = st_r.retry_cnt + 1'b1;
        st_nxt.bo_retry  = (st_r.retry_cnt >= CW'(RESTART_CYC - 1));
      end
    end

    // ---------------------------------------------------------------------------
    // Operating mode
    // ---------------------------------------------------------------------------
    case (st_r.mode)
      pfc_fault_pkg::MODE_STARTUP: begin
        st_nxt.su_cnt = st_r.su_cnt + 1'b1;
        if (st_r.link >= pfc_fault_pkg::NOMINAL_LINK_CODE) begin
          st_nxt.mode       = pfc_fault_pkg::MODE_NORMAL;
          st_nxt.su_cnt     = '0;
          st_nxt.settle_cnt = '0;
        end else if (st_r.su_cnt >= CW'(STARTUP_LIMIT_CYC - 1)) begin
          st_nxt.mode   = pfc_fault_pkg::MODE_OVERPOWER;
          st_nxt.op_cnt = '0;
        end
      end

      pfc_fault_pkg::MODE_NORMAL: begin
        if (st_r.settle_cnt >= CW'(OSC_SETTLE_CYC - 1)) begin
          st_nxt.osc_cnt = '0;
        end else begin
          st_nxt.settle_cnt = st_r.settle_cnt + 1'b1;
        end
        if (st_r.link < pfc_fault_pkg::STARTUP_ENTER_CODE) begin
          st_nxt.su_cnt  = '0;
          st_nxt.osc_cnt = st_r.osc_cnt + 1'b1;
          if (st_r.osc_cnt + 3'h1 >= pfc_fault_pkg::OSC_ENTRY_LIMIT) begin
            st_nxt.mode   = pfc_fault_pkg::MODE_OVERPOWER;
            st_nxt.op_cnt = '0;
          end else begin
            st_nxt.mode = pfc_fault_pkg::MODE_STARTUP;
          end
        end
      end

      pfc_fault_pkg::MODE_OVERPOWER: begin
        // rest then retry after 3 s
        st_nxt.op_cnt = st_r.op_cnt + 1'b1;
        if (st_r.op_cnt >= CW'(RESTART_CYC - 1)) begin
          st_nxt.mode    = pfc_fault_pkg::MODE_STARTUP;
          st_nxt.su_cnt  = '0;
          st_nxt.osc_cnt = '0;
        end
      end

      pfc_fault_pkg::MODE_STANDBY: begin
        if (!standby) begin
          st_nxt.mode    = pfc_fault_pkg::MODE_STARTUP;
          st_nxt.su_cnt  = '0;
          st_nxt.osc_cnt = '0;
        end
      end

      default: begin
        st_nxt.mode = pfc_fault_pkg::MODE_STARTUP;
      end
    endcase

    // Standby overrides the mode chosen above
    // low-power request stops operation
    if (standby) begin
      st_nxt.mode       = pfc_fault_pkg::MODE_STANDBY;
      st_nxt.su_cnt     = '0;
      st_nxt.op_cnt     = '0;
      st_nxt.settle_cnt = '0;
      st_nxt.osc_cnt    = '0;
    end

    st_nxt.gate = !standby
                  && st_r.mode != pfc_fault_pkg::MODE_OVERPOWER
                  && st_r.mode != pfc_fault_pkg::MODE_STANDBY
                  && !st_nxt.ovp
                  && !st_nxt.loop_fault
                  && (!st_r.brownout || st_r.bo_retry);

    // Status flags trail the state by one cycle
    st_nxt.status.startup     = (st_r.mode == pfc_fault_pkg::MODE_STARTUP);
    st_nxt.status.overvoltage = st_r.ovp;
    st_nxt.status.loop_fault  = st_r.loop_fault;
    st_nxt.status.brownout    = st_r.brownout;
    st_nxt.status.overpower   = (st_r.mode == pfc_fault_pkg::MODE_OVERPOWER);
    st_nxt.status.low_power   = standby;
  end

  // ---------------------------------------------------------------------------
  // Register update
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r       <= '0;
      st_r.lp_s1 <= 1'b1;
      st_r.lp_s2 <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state register
  assign gate_enable_r   = st_r.gate;
  assign status_r        = st_r.status;
  assign link_error_r    = st_r.err;
  assign on_time_limit_r = st_r.on_lim;
  assign line_peak_r     = st_r.peak_out;

endmodule

// ---- testbench/pfc_fault_supervisor_properties.sv ----
// Purpose: Concurrent checks on the PFC fault supervisor ports
// Assumes: Bound to every supervisor instance; shortened counts passed in
// Notes:   Held sense codes and peak run lengths are tracked beside the design
`timescale 1ns/1ps
module pfc_fault_supervisor_properties #(
  parameter int          BROWNOUT_CYC   = pfc_fault_pkg::BROWNOUT_CYC,
  parameter logic [11:0] BROWNOUT_LOWER = pfc_fault_pkg::BROWNOUT_LOWER_DEF,
  parameter logic [11:0] BROWNOUT_UPPER = pfc_fault_pkg::BROWNOUT_UPPER_DEF
) (
  input wire logic                              sys_clk,
  input wire logic                              rst,
  input wire pfc_fault_pkg::sense_sample_t      sample,
  input wire logic                              low_power_request_n,
  input wire logic                              gate_enable_r,
  input wire pfc_fault_pkg::supervisor_status_t status_r,
  input wire logic signed [12:0]                link_error_r,
  input wire logic [15:0]                       on_time_limit_r,
  input wire logic [11:0]                       line_peak_r
);
  // ---------------------------------------------------------------------------
  // Held codes and run lengths
  // ---------------------------------------------------------------------------
  logic        seen_r;
  logic [11:0] link_r;
  logic [11:0] line_r;
  int          low_run_r;
  int          high_run_r;
  logic [15:0] on_exp;
  always_comb on_exp = pfc_fault_pkg::ON_TIME_NUM / ((line_r == 12'h000) ? 16'h0001 : {4'h0, line_r});
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      seen_r     <= 1'b0;
      link_r     <= 12'h000;
      line_r     <= 12'h000;
      low_run_r  <= 0;
      high_run_r <= 0;
    end else begin
      if (sample.valid) begin
        seen_r <= 1'b1;
        link_r <= sample.link;
        line_r <= sample.line;
      end
      low_run_r  <= (line_peak_r < BROWNOUT_LOWER) ? low_run_r + 1 : 0;
      high_run_r <= (line_peak_r > BROWNOUT_UPPER) ? high_run_r + 1 : 0;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_ovp_hit;
    sample.valid && (sample.link > pfc_fault_pkg::OVP_CODE);
  endsequence
  sequence s_standby_held;
    !low_power_request_n [*5];
  endsequence
  sequence s_codes_settled;
    (seen_r && $stable(link_r) && $stable(line_r)) [*3];
  endsequence
  property p_reset_clear;
    @(posedge sys_clk) disable iff (1'b0)
      rst |=> !gate_enable_r && (status_r == '0) && (line_peak_r == 12'h000);
  endproperty
  property p_ovp_stop;
    s_ovp_hit |-> ##[1:2] !gate_enable_r;
  endproperty
  property p_ovp_flag;
    s_ovp_hit |-> ##[1:3] status_r.overvoltage;
  endproperty
  property p_loop_stop;
    sample.valid && (sample.link < sample.line) |-> ##[1:2] !gate_enable_r;
  endproperty
  property p_standby_stop;
    s_standby_held |-> !gate_enable_r ##1 status_r.low_power;
  endproperty
  property p_link_error;
    s_codes_settled |-> link_error_r == (13'sh190 - $signed({1'b0, link_r}));
  endproperty
  property p_on_time;
    s_codes_settled |-> on_time_limit_r == on_exp;
  endproperty
  property p_peak_clamp;
    line_peak_r <= pfc_fault_pkg::LINE_CLAMP_CODE;
  endproperty
  property p_peak_step;
    !$past(rst) && (line_peak_r < $past(line_peak_r)) |-> ($past(line_peak_r) - line_peak_r) <= 12'h005;
  endproperty
  property p_brownout_set;
    $rose(status_r.brownout) |-> low_run_r >= BROWNOUT_CYC;
  endproperty
  property p_brownout_clear;
    !$past(rst) && $fell(status_r.brownout) |-> high_run_r >= BROWNOUT_CYC - 2;
  endproperty
  property p_gate_fault;
    gate_enable_r |-> !(status_r.overpower || status_r.low_power) ##1 !(status_r.overvoltage || status_r.loop_fault);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared by reset");
  a_ovp_stop: assert property (p_ovp_stop) else $error("gate kept on above overvoltage");
  a_ovp_flag: assert property (p_ovp_flag) else $error("overvoltage flag missing");
  a_loop_stop: assert property (p_loop_stop) else $error("gate kept on with link below line");
  a_standby_stop: assert property (p_standby_stop) else $error("standby did not stop drive");
  a_link_error: assert property (p_link_error) else $error("link error value wrong");
  a_on_time: assert property (p_on_time) else $error("on-time ceiling wrong");
  a_peak_clamp: assert property (p_peak_clamp) else $error("peak above clamp");
  a_peak_step: assert property (p_peak_step) else $error("peak fell more than one step");
  a_brownout_set: assert property (p_brownout_set) else $error("brownout declared early");
  a_brownout_clear: assert property (p_brownout_clear) else $error("brownout left early");
  a_gate_fault: assert property (p_gate_fault) else $error("gate on with fault active");
endmodule

bind pfc_fault_supervisor pfc_fault_supervisor_properties #(
  .BROWNOUT_CYC(BROWNOUT_CYC), .BROWNOUT_LOWER(BROWNOUT_LOWER), .BROWNOUT_UPPER(BROWNOUT_UPPER)
) pfc_fault_supervisor_properties_i (
  .sys_clk(sys_clk), .rst(rst), .sample(sample), .low_power_request_n(low_power_request_n),
  .gate_enable_r(gate_enable_r), .status_r(status_r), .link_error_r(link_error_r),
  .on_time_limit_r(on_time_limit_r), .line_peak_r(line_peak_r));

// ---- testbench/power_stage_model.sv ----
// Purpose: Boost stage and sense network giving digitised sense codes
// Assumes: One conversion a cycle, or one in four when slow
// Notes:   Between conversions the code fields carry inverted values
`timescale 1ns/1ps
module power_stage_model (
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire logic [11:0]             link_v,
  input  wire logic [11:0]             line_v,
  input  wire logic                    slow,
  input  wire logic                    fb_fail,
  input  wire logic                    ac_fail,
  output pfc_fault_pkg::sense_sample_t sample
);
  logic [11:0] link_r;
  logic [11:0] line_r;
  logic [3:0]  div_r;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      link_r <= 12'h000;
      line_r <= 12'h000;
      div_r  <= 4'h0;
      sample <= '0;
    end else begin
      div_r <= div_r + 4'h1;
      if (!fb_fail) begin
        link_r <= link_v;
      end else if (div_r == 4'h0 && link_r != 12'h000) begin
        link_r <= link_r - 12'h001;
      end
      line_r <= ac_fail ? 12'h000 : line_v;
      if (slow && div_r[1:0] != 2'h3) begin
        sample <= {1'b0, ~link_r, ~line_r};
      end else begin
        sample <= {1'b1, link_r, line_r};
      end
    end
  end
endmodule

// ---- testbench/pfc_fault_supervisor_bench.sv ----
// Purpose: Self-checking bench for the PFC fault supervisor
// Assumes: Shortened counts; 40 MHz clock
// Notes:   Expected values are worked out from integer sense codes
`timescale 1ns/1ps
module pfc_fault_supervisor_bench;
  localparam int TRC = 20;
  localparam int BOC = 50;
  localparam int RSC = 200;
  localparam int SUL = 300;
  localparam int GATE = 0, LOWP = 1, OVPW = 2, BROWN = 3, LOOPF = 4, OVERV = 5, START = 6;
  logic                              sys_clk;
  logic                              rst;
  logic                              low_power_request_n;
  logic [11:0]                       link_v;
  logic [11:0]                       line_v;
  logic                              slow;
  logic                              fb_fail;
  logic                              ac_fail;
  int                                err_count;
  int                                checks_done;
  int                                cyc;
  int                                n;
  int                                lv;
  int                                ln;
  logic [11:0]                       pk;
  pfc_fault_pkg::sense_sample_t      sample;
  pfc_fault_pkg::supervisor_status_t status_r;
  logic                              gate_enable_r;
  logic signed [12:0]                link_error_r;
  logic [15:0]                       on_time_limit_r;
  logic [11:0]                       line_peak_r;
  logic [6:0]                        obs;
  assign obs = {status_r, gate_enable_r};
  power_stage_model power_stage_model_i (.sys_clk(sys_clk), .rst(rst), .link_v(link_v), .line_v(line_v),
    .slow(slow), .fb_fail(fb_fail), .ac_fail(ac_fail), .sample(sample));
  pfc_fault_supervisor #(.TROUGH_CYC(TRC), .BROWNOUT_CYC(BOC), .RESTART_CYC(RSC), .STARTUP_LIMIT_CYC(SUL),
    .OSC_SETTLE_CYC(100)) pfc_fault_supervisor_i (.sys_clk(sys_clk), .rst(rst), .sample(sample),
    .low_power_request_n(low_power_request_n), .gate_enable_r(gate_enable_r), .status_r(status_r),
    .link_error_r(link_error_r), .on_time_limit_r(on_time_limit_r), .line_peak_r(line_peak_r));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s: seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("Checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Waits a bounded time for one output bit, then compares it
  task automatic wait_bit(input int i, input logic v, input int lim, input string what);
    for (n = 0; n < lim && obs[i] !== v; n++) begin
      @(negedge sys_clk);
    end
    check({15'h0000, obs[i]}, {15'h0000, v}, what);
  endtask
  task automatic set_in(input int lk, input int lw);
    @(posedge sys_clk);
    link_v <= 12'(lk);
    line_v <= 12'(lw);
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      $display("[FAIL] %0t run exceeded its cycle budget", $time);
      test_done;
    end
  end
  initial begin
    rst = 1'b1;
    low_power_request_n = 1'b1;
    link_v = 12'h199;
    line_v = 12'h06E;
    slow = 1'b0;
    fb_fail = 1'b0;
    ac_fail = 1'b0;
    err_count = 0;
    checks_done = 0;
    cyc = 0;
    lv = $urandom(32'h3DFE3895);
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    check({9'h000, obs}, 16'h0000, "reset outputs");
    for (int k = 0; k < 12; k++) begin
      lv = 400 + $urandom % 20;
      ln = 96 + $urandom % 32;
      set_in(lv, ln);
      slow <= 1'($urandom % 2);
      repeat (14) @(negedge sys_clk);
      check({3'h0, link_error_r}, {3'h0, 13'(400 - lv)}, "link error");
      check(on_time_limit_r, 16'(1126000 / 25 / ln), "on-time ceiling");
      check({15'h0000, gate_enable_r}, 16'h0001, "gate in normal");
    end
    $display("test regulation done");
    set_in(420, 110);
    repeat (10) @(negedge sys_clk);
    check({15'h0000, gate_enable_r}, 16'h0001, "no trip at limit");
    set_in(421, 110);
    wait_bit(OVERV, 1'b1, 12, "overvoltage flag");
    check({15'h0000, gate_enable_r}, 16'h0000, "overvoltage stop");
    set_in(410, 110);
    repeat (10) @(negedge sys_clk);
    check({15'h0000, gate_enable_r}, 16'h0000, "held within hysteresis");
    set_in(409, 110);
    wait_bit(GATE, 1'b1, 12, "resume below hysteresis");
    $display("test overvoltage done");
    set_in(361, 110);
    repeat (10) @(negedge sys_clk);
    check({15'h0000, obs[START]}, 16'h0000, "normal above entry");
    set_in(359, 110);
    wait_bit(START, 1'b1, 12, "back to start-up");
    set_in(399, 110);
    repeat (10) @(negedge sys_clk);
    check({15'h0000, obs[START]}, 16'h0001, "start-up below nominal");
    set_in(409, 110);
    wait_bit(START, 1'b0, 12, "normal at nominal");
    check({15'h0000, obs[OVPW]}, 16'h0000, "single drop tolerated");
    repeat (120) @(posedge sys_clk);
    $display("test start-up modes done");
    set_in(409, 380);
    @(posedge sys_clk);
    fb_fail <= 1'b1;
    wait_bit(GATE, 1'b0, 6000, "loop fault stop in time");
    wait_bit(LOOPF, 1'b1, 4, "loop fault flag");
    set_in(120, 100);
    fb_fail <= 1'b0;
    repeat (10) @(negedge sys_clk);
    check({15'h0000, gate_enable_r}, 16'h0000, "held while link under peak");
    set_in(409, 110);
    wait_bit(GATE, 1'b1, 24, "loop fault recovery");
    $display("test loop fault done");
    @(posedge sys_clk);
    low_power_request_n <= 1'b0;
    wait_bit(GATE, 1'b0, 5, "standby stop");
    wait_bit(LOWP, 1'b1, 3, "standby flag");
    @(posedge sys_clk);
    low_power_request_n <= 1'b1;
    wait_bit(GATE, 1'b1, 14, "standby release");
    $display("test standby done");
    set_in(409, 200);
    repeat (2 * TRC + 4) @(negedge sys_clk);
    check({4'h0, line_peak_r}, 16'h0080, "peak clamp");
    @(posedge sys_clk);
    ac_fail <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      pk = line_peak_r;
      for (n = 0; n < 2 * TRC + 4 && line_peak_r === pk; n++) begin
        @(negedge sys_clk);
      end
      check({4'h0, line_peak_r}, 16'(128 - 5 * (k + 1)), "peak step");
    end
    wait_bit(BROWN, 1'b1, 300, "brownout on open line sense");
    wait_bit(GATE, 1'b0, 4, "brownout stop");
    wait_bit(GATE, 1'b1, RSC + TRC + 10, "brownout retry");
    wait_bit(GATE, 1'b0, TRC + 10, "retry window end");
    @(posedge sys_clk);
    ac_fail <= 1'b0;
    wait_bit(BROWN, 1'b0, BOC + 2 * TRC + 10, "brownout exit");
    $display("test brownout done");
    repeat (120) @(posedge sys_clk);
    for (int k = 0; k < 4; k++) begin
      set_in(409, 110);
      repeat (10) @(negedge sys_clk);
      set_in(340, 110);
      repeat (10) @(negedge sys_clk);
    end
    wait_bit(OVPW, 1'b1, 20, "oscillation overpower");
    check({15'h0000, gate_enable_r}, 16'h0000, "overpower stop");
    wait_bit(OVPW, 1'b0, RSC + 10, "overpower retry");
    wait_bit(OVPW, 1'b1, SUL + 20, "start-up too long");
    $display("test overpower done");
    test_done;
  end
endmodule
